//--- pwm6_counter.sv
`timescale 1ns/1ps

module pwm6_counter
   import pwm6_pkg::*;
(
   input  wire logic   ref_clk,
   input  wire logic   reset,
   pwm_wave_if.gen     wif
);

   typedef struct packed
   {
      logic [CNT_W-1:0] cnt;
      count_dir_t       dir;
      logic             wave;
      logic             ovf;
   } cnt_state_t;

   cnt_state_t state_reg;
   cnt_state_t state_next;

   // ==========================================
   // Counter and waveform
   always_comb
   begin
      state_next     = state_reg;
      state_next.ovf = 1'b0;
      if (!wif.active)
      begin
         state_next.cnt = CNT_RESET;
         state_next.dir = DIR_UP;
         state_next.wave = 1'b0;
      end
      else if (!wif.dual_slope)
      begin
         // [RQ5] Count up, wrap
         // [RQ7] Clear after TOP match
         if (state_reg.cnt == wif.top)
         begin
            state_next.cnt = CNT_BOTTOM;
            // [RQ6] Opposite level at wrap
            state_next.wave = 1'b0;
         end
         else
         begin
            state_next.cnt = state_reg.cnt + 8'h01;
            // [RQ6] Set on compare match
            if (state_reg.cnt + 8'h01 == wif.compare)
            begin
               state_next.wave = 1'b1;
            end
         end
         // [RQ8] Flag at TOP
         if (state_next.cnt == wif.top)
         begin
            state_next.ovf = 1'b1;
         end
         state_next.dir = DIR_UP;
      end
      else
      begin
         // [RQ9] Up to TOP then down
         if (state_reg.dir == DIR_UP)
         begin
            if (state_reg.cnt >= wif.top)
            begin
               state_next.dir = DIR_DOWN;
               state_next.cnt = (state_reg.cnt == CNT_BOTTOM) ? CNT_BOTTOM
                                                              : state_reg.cnt - 8'h01;
            end
            else
            begin
               state_next.cnt = state_reg.cnt + 8'h01;
            end
         end
         else
         begin
            if (state_reg.cnt == CNT_BOTTOM)
            begin
               state_next.dir = DIR_UP;
               state_next.cnt = (wif.top == CNT_BOTTOM) ? CNT_BOTTOM : 8'h01;
            end
            else
            begin
               state_next.cnt = state_reg.cnt - 8'h01;
            end
         end
         // [RQ10] Up match sets, down match clears
         if (state_next.cnt == wif.compare)
         begin
            state_next.wave = (state_next.dir == DIR_UP);
         end
         // [RQ11] Flag at BOTTOM
         if (state_next.cnt == CNT_BOTTOM && state_reg.cnt != CNT_BOTTOM)
         begin
            state_next.ovf = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_reg <= '{cnt: CNT_RESET, dir: DIR_UP, wave: 1'b0, ovf: 1'b0};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign wif.count        = state_reg.cnt;
   assign wif.wave         = state_reg.wave;
   assign wif.overflow_evt = state_reg.ovf;

endmodule

//--- pwm6_pkg.sv
package pwm6_pkg;

   // ==========================================
   // Widths and field layout
   localparam int CNT_W          = 8;
   localparam int PIN_COUNT      = 6;
   localparam int PAIR_COUNT     = 3;
   localparam int MODE_W         = 2;
   localparam int WGM_HI_BIT     = 1;
   localparam int WGM_LO_BIT     = 0;
   localparam int OMODE_HI_BIT   = 1;
   localparam int OMODE_LO_BIT   = 0;

   // ==========================================
   // Reset values and mode encodings
   localparam logic [7:0] CNT_RESET       = 8'h00;
   localparam logic [7:0] CNT_BOTTOM      = 8'h00;
   localparam logic [5:0] PINS_RESET      = 6'h00;
   localparam logic [1:0] OMODE_OFF       = 2'h0;
   localparam logic [1:0] OMODE_BOTH      = 2'h1;

   typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage

//--- pwm_wave_if.sv
`timescale 1ns/1ps

interface pwm_wave_if;
   import pwm6_pkg::*;

   logic               active;
   logic               dual_slope;
   logic [CNT_W-1:0]   compare;
   logic [CNT_W-1:0]   top;
   logic [CNT_W-1:0]   count;
   logic               wave;
   logic               overflow_evt;

   modport gen
   (
      input  active,
      input  dual_slope,
      input  compare,
      input  top,
      output count,
      output wave,
      output overflow_evt
   );

   modport ctl
   (
      output active,
      output dual_slope,
      output compare,
      output top,
      input  count,
      input  wave,
      input  overflow_evt
   );
endinterface

//--- six_output_pwm_timer.sv
`timescale 1ns/1ps

// Contract
// [RQ1] Six-output mode when channel A enable is one and mode field is 1X.
// [RQ2] One waveform from channel A compare drives all six pins.
// [RQ3] Per-pin override enable acts at once, no counter event waited.
// [RQ4] Override enable zero shows the port output register bit.
// [RQ5] Single slope counts zero up to TOP then restarts at zero.
// [RQ6] Single slope sets at compare match, clears at wrap to zero.
// [RQ7] Single slope clears the counter one cycle after matching TOP.
// [RQ8] Single slope sets overflow flag each time counter reaches TOP.
// [RQ9] Dual slope counts zero up to TOP and back down.
// [RQ10] Dual slope: one level at up match, opposite at down match.
// [RQ11] Dual slope sets overflow flag each time counter reaches zero.
// [RQ12] Output mode 00 off, 01 both, 1X first off, complement on.
// [RQ13] Complement pins carry inverse waveform; overflow flag sticky until cleared.
module six_output_pwm_timer
   import pwm6_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   input  wire logic                  chan_a_pwm_enable,
   input  wire logic [MODE_W-1:0]     waveform_mode_field,
   input  wire logic [CNT_W-1:0]      chan_a_compare_reg,
   input  wire logic [CNT_W-1:0]      top_value_reg,
   input  wire logic [MODE_W-1:0]     chan_a_output_mode,
   input  wire logic [PIN_COUNT-1:0]  pin_override_enable_reg,
   input  wire logic [PIN_COUNT-1:0]  port_output_reg,
   input  wire logic                  overflow_clear,
   output logic [PIN_COUNT-1:0]       compare_output_pin,
   output logic [CNT_W-1:0]           counter_value,
   output logic                       overflow_flag,
   output logic                       pwm6_active
);

   typedef struct packed
   {
      logic [PIN_COUNT-1:0] pins;
      logic [CNT_W-1:0]     cnt;
      logic                 ovf;
      logic                 active;
   } top_state_t;

   top_state_t state_reg;
   top_state_t state_next;

   pwm_wave_if wif ();

   // ==========================================
   // Pair routing
   function automatic logic [1:0] pair_drive
   (
      input logic [MODE_W-1:0] mode
   );
      logic [1:0] res;
      res = 2'h0;
      // [RQ12] Pair connection by mode
      case (mode)
         OMODE_OFF:  res = 2'h0;
         OMODE_BOTH: res = 2'h3;
         default:    res = 2'h2;
      endcase
      // Bit 0 = true pin, bit 1 = complement pin
      return res;
   endfunction

   // ==========================================
   // Mode decode
   // [RQ1] Enable plus mode field 1X
   assign wif.active     = chan_a_pwm_enable && waveform_mode_field[WGM_HI_BIT];
   assign wif.dual_slope = waveform_mode_field[WGM_LO_BIT];
   assign wif.compare    = chan_a_compare_reg;
   assign wif.top        = top_value_reg;

   pwm6_counter u_counter
   (
      .ref_clk (ref_clk),
      .reset   (reset),
      .wif     (wif)
   );

   // ==========================================
   // Pin mux and flag
   always_comb
   begin
      logic [1:0] conn;
      logic       wave_pin;
      conn              = pair_drive(chan_a_output_mode);
      wave_pin          = 1'h0;
      state_next        = state_reg;
      state_next.cnt    = wif.count;
      state_next.active = wif.active;
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         // [RQ2] Shared waveform to all pins
         // [RQ13] Odd pins carry the inverse
         wave_pin = (i % 2 == 1) ? ~wif.wave : wif.wave;
         // [RQ3] Override enable gates directly
         // [RQ4] Port value when disabled
         if (wif.active && pin_override_enable_reg[i] && conn[i % 2])
         begin
            state_next.pins[i] = wave_pin;
         end
         else
         begin
            state_next.pins[i] = port_output_reg[i];
         end
      end
      // [RQ13] Sticky flag, set beats clear
      if (wif.overflow_evt)
      begin
         state_next.ovf = 1'b1;
      end
      else if (overflow_clear)
      begin
         state_next.ovf = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_reg <= '{pins: PINS_RESET, cnt: CNT_RESET, ovf: 1'b0, active: 1'b0};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign compare_output_pin = state_reg.pins;
   assign counter_value      = state_reg.cnt;
   assign overflow_flag      = state_reg.ovf;
   assign pwm6_active        = state_reg.active;

endmodule

//--- pwm6_checker.sv
`timescale 1ns/1ps
// ==========================================
// Port-level checks of the six-output timer
module pwm6_checker
   import pwm6_pkg::*;
(
   input wire logic                 ref_clk,
   input wire logic                 reset,
   input wire logic                 chan_a_pwm_enable,
   input wire logic [MODE_W-1:0]    waveform_mode_field,
   input wire logic [CNT_W-1:0]     top_value_reg,
   input wire logic [MODE_W-1:0]    chan_a_output_mode,
   input wire logic [PIN_COUNT-1:0] pin_override_enable_reg,
   input wire logic [PIN_COUNT-1:0] port_output_reg,
   input wire logic [PIN_COUNT-1:0] compare_output_pin,
   input wire logic [CNT_W-1:0]     counter_value,
   input wire logic                 overflow_flag,
   input wire logic                 pwm6_active
);
   wire       on = chan_a_pwm_enable & waveform_mode_field[WGM_HI_BIT];
   wire       sgl = pwm6_active & on & ~waveform_mode_field[WGM_LO_BIT];
   wire       dbl = pwm6_active & on & waveform_mode_field[WGM_LO_BIT];
   wire       at_top = counter_value == top_value_reg;
   wire [5:0] pin = compare_output_pin;
   wire [5:0] prt = port_output_reg;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_mode_exit: assert property ((!on) [*2] |=> pin == $past(prt))
      else $error("pins not on port");
   chk_ovr_off: assert property (pin_override_enable_reg == PINS_RESET |=> pin == $past(prt))
      else $error("override off ignored");
   chk_even_off: assert property (chan_a_output_mode[1] |=> (pin & 6'h15) == ($past(prt) & 6'h15))
      else $error("even pin driven");
   chk_pair_inv:
      assert property ((on && &pin_override_enable_reg && chan_a_output_mode == OMODE_BOTH) [*2]
         |=> pin == {3{~pin[0], pin[0]}})
      else $error("pair not inverse");
   chk_single_wrap: assert property (sgl && at_top |=> counter_value == CNT_BOTTOM)
      else $error("no wrap");
   chk_single_ovf: assert property (sgl && at_top |-> ##[0:2] overflow_flag)
      else $error("no flag at top");
   chk_dual_turn: assert property (dbl && at_top |=> counter_value == top_value_reg - 8'h01)
      else $error("no turn");
   chk_dual_ovf:
      assert property (dbl && counter_value == CNT_BOTTOM && $past(counter_value) == 8'h01
         |-> ##[0:2] overflow_flag)
      else $error("no flag at bottom");
   cov_single: cover property (sgl && at_top);
   cov_dual: cover property (dbl && at_top);
   cov_ovr: cover property (on && pin_override_enable_reg == PINS_RESET);
endmodule

bind six_output_pwm_timer pwm6_checker chk
(
   .ref_clk                 (ref_clk),
   .reset                   (reset),
   .chan_a_pwm_enable       (chan_a_pwm_enable),
   .waveform_mode_field     (waveform_mode_field),
   .top_value_reg           (top_value_reg),
   .chan_a_output_mode      (chan_a_output_mode),
   .pin_override_enable_reg (pin_override_enable_reg),
   .port_output_reg         (port_output_reg),
   .compare_output_pin      (compare_output_pin),
   .counter_value           (counter_value),
   .overflow_flag           (overflow_flag),
   .pwm6_active             (pwm6_active)
);

//--- motor_stage.sv
`timescale 1ns/1ps
// ==========================================
// Driver stage: times the pulse train on pin 0
module motor_stage
   import pwm6_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic [PIN_COUNT-1:0] drive_pins,
   output logic                      period_done,
   output logic [31:0]               period_info
);
   logic [15:0] hi_reg;
   logic [15:0] per_reg;
   logic        last_reg;
   // First report after a change is partial, so the bench drops it
   always_ff @(posedge ref_clk)
   begin
      last_reg <= drive_pins[0];
      period_done <= drive_pins[0] & ~last_reg;
      hi_reg <= drive_pins[0] & ~last_reg ? 16'h0001 : hi_reg + 16'(drive_pins[0]);
      per_reg <= drive_pins[0] & ~last_reg ? 16'h0001 : per_reg + 16'h0001;
      if (drive_pins[0] & ~last_reg)
         period_info <= {per_reg, hi_reg};
   end
endmodule

//--- test_six_output_pwm_timer.sv
`timescale 1ns/1ps
module test_six_output_pwm_timer;
   import pwm6_pkg::*;
   logic                 ref_clk, reset, en, clr, flag, done, act;
   logic [MODE_W-1:0]    wmode, omode;
   logic [CNT_W-1:0]     cmp, top, cnt_val;
   logic [PIN_COUNT-1:0] ovr, port, pins;
   logic [31:0]          meas;
   logic [31:0]          exp_q[$];
   int                   n_fail, n_checks, cyc;

   six_output_pwm_timer dut (.ref_clk, .reset, .chan_a_pwm_enable(en),
      .waveform_mode_field(wmode), .chan_a_compare_reg(cmp), .top_value_reg(top),
      .chan_a_output_mode(omode), .pin_override_enable_reg(ovr), .port_output_reg(port),
      .overflow_clear(clr), .compare_output_pin(pins), .counter_value(cnt_val),
      .overflow_flag(flag), .pwm6_active(act));
   motor_stage stage (.ref_clk, .drive_pins(pins), .period_done(done), .period_info(meas));

   // ==========================================
   // Compare and closing tasks
   task automatic check_lvl(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic check_period(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value period_high exp %h got %h", e, g);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [5:0] conn(input logic [1:0] m, input logic [5:0] o);
      return o & (m == OMODE_BOTH ? 6'h3F : m[1] ? 6'h2A : 6'h00);
   endfunction
   // Counter stopped between runs so each run starts from zero
   task automatic run_pwm(input logic dual);
      logic [7:0] t;
      logic [7:0] c;
      t = 8'(4 + $urandom % 17);
      c = 8'(1 + $urandom % (t - 1));
      @(posedge ref_clk) #1;
      en = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      top = t;
      cmp = c;
      wmode = {1'b1, dual};
      en = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      check_lvl("active", 8'h01, {7'h00, act});
      check_lvl("count", 8'h01, cnt_val);
      repeat (2) @(posedge done);
      @(posedge ref_clk) #1;
      exp_q.push_back(dual ? {16'(2 * t), 16'(2 * (t - c))} : {16'(t + 1), 16'(t - c + 1)});
      wait (exp_q.size() == 0);
   endtask

   // ==========================================
   // Clock, watchdog and result monitor
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         print_verdict;
      end
      if (done && exp_q.size() > 0)
         check_period(exp_q.pop_front(), meas);
   end

   initial
   begin
      void'($urandom(32'h3ED0E898));
      {en, clr, wmode, omode, cmp, top, ovr, port} = '0;
      reset = 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      ovr = 6'h3F;
      omode = OMODE_BOTH;
      for (int i = 0; i < 6; i++)
         run_pwm(i[0]);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk) #1;
         omode = i[1:0];
         ovr = i == 0 ? 6'h00 : 6'($urandom);
         port = 6'($urandom);
         @(posedge ref_clk) #1;
         check_lvl("pins", {2'h0, port & ~conn(omode, ovr)},
            {2'h0, pins & ~conn(omode, ovr)});
      end
      en = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      check_lvl("flag", 8'h01, {7'h00, flag});
      check_lvl("active", 8'h00, {7'h00, act});
      check_lvl("count", 8'h00, cnt_val);
      clr = 1'b1;
      @(posedge ref_clk) #1;
      clr = 1'b0;
      @(posedge ref_clk) #1;
      check_lvl("flag", 8'h00, {7'h00, flag});
      print_verdict;
   end
endmodule
